// ### hdl/rdmt_map.svh
// Constants of the radar DMA transfer block: lane count, per-element costs.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef RDMT_MAP_SVH
`define RDMT_MAP_SVH

// Width of one bus beat in bytes (128-bit memory data path)
`define RDMT_LANES 16
// Width of the engine cost field
`define RDMT_COST_W 4
// Cycles spent per beat or element in each mode
`define RDMT_COST_CONT 4'h1
`define RDMT_COST_TWRITE 4'h4
`define RDMT_COST_TREAD 4'h1
// Low address bits that select the byte within one beat
`define RDMT_LANE_SHIFT 4

`endif

// ### hdl/rdmt_pkg.sv
// Types shared by the radar DMA transfer block.
// Assumes no other package; nothing here is imported elsewhere.
package rdmt_pkg;

  // Transfer mode as programmed with the descriptor
  typedef enum logic [1:0] {
    RDMT_MODE_CONTIG = 2'h0,
    RDMT_MODE_TWRITE = 2'h1,
    RDMT_MODE_TREAD = 2'h2
  } rdmt_mode_t;

  // Per-engine element walker
  typedef enum logic [1:0] {
    RDMT_ENG_IDLE = 2'h0,
    RDMT_ENG_RUN = 2'h1,
    RDMT_ENG_DRAIN = 2'h3
  } rdmt_eng_state_t;

  // Descriptor controller
  typedef enum logic [1:0] {
    RDMT_CTL_IDLE = 2'h0,
    RDMT_CTL_LAUNCH = 2'h1,
    RDMT_CTL_WAIT = 2'h3
  } rdmt_ctl_state_t;

endpackage : rdmt_pkg

// ### hdl/rdmt_xfer_engine.sv
// One transfer engine: walks a list of elements, reads each and writes it.
// Assumes read data is valid in the cycle the read port grants the request.
`timescale 1ns/1ps
`include "rdmt_map.svh"

module rdmt_xfer_engine #(
  parameter int ADDR_W = 32,
  parameter int CNT_W = 16,
  parameter int DATA_W = 128,
  parameter int LANES = DATA_W / 8,
  parameter int BW = $clog2(LANES) + 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Job setup: count and start addresses sampled with start; sizes, steps and cost are used live
  input wire logic start,
  input wire logic [CNT_W-1:0] num_elem,
  input wire logic [BW-1:0] elem_bytes,
  input wire logic [BW-1:0] last_bytes,
  input wire logic [ADDR_W-1:0] src_start,
  input wire logic [ADDR_W-1:0] dst_start,
  input wire logic [ADDR_W-1:0] src_step,
  input wire logic [ADDR_W-1:0] dst_step,
  input wire logic [`RDMT_COST_W-1:0] cost,
  // Status
  output logic busy,
  output logic done,
  // Read port
  output logic rd_req,
  output logic [ADDR_W-1:0] rd_addr,
  output logic [LANES-1:0] rd_be,
  input wire logic rd_ready,
  input wire logic [DATA_W-1:0] rd_data,
  // Write port
  output logic wr_req,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [LANES-1:0] wr_be,
  output logic [DATA_W-1:0] wr_data,
  input wire logic wr_ready
);

  // Low-lane byte mask for a byte count
  function automatic logic [LANES-1:0] be_mask(input logic [BW-1:0] bytes);
    logic [LANES-1:0] m;
    m = '0;
    for (int i = 0; i < LANES; i++) begin
      m[i] = (BW'(i) < bytes);
    end
    return m;
  endfunction : be_mask

  rdmt_pkg::rdmt_eng_state_t state, next_state;
  logic [ADDR_W-1:0] src_ptr, next_src_ptr, dst_ptr, next_dst_ptr;
  logic [CNT_W-1:0] issue_left, next_issue_left, wr_left, next_wr_left;
  logic [`RDMT_COST_W-1:0] pace, next_pace;
  logic [LANES-1:0] cur_be, next_cur_be, full_be, last_be;
  logic hold_valid, next_hold_valid;
  logic [ADDR_W-1:0] hold_addr, next_hold_addr;
  logic [LANES-1:0] hold_be, next_hold_be;
  logic [DATA_W-1:0] hold_data, next_hold_data;
  logic next_done;
  logic rd_fire, wr_fire;

  assign full_be = be_mask(elem_bytes);
  assign last_be = be_mask(last_bytes);

  // One holding slot; a read may refill it in the cycle it drains, so beats flow each cycle
  assign rd_req = (state == rdmt_pkg::RDMT_ENG_RUN) && (issue_left != '0) && (pace == '0)
                  && (!hold_valid || wr_ready);
  assign rd_fire = rd_req && rd_ready;
  assign wr_fire = hold_valid && wr_ready;

  // Next state of the walker, pointers, pacing and holding slot
  always_comb begin
    next_state = state;
    next_src_ptr = src_ptr;
    next_dst_ptr = dst_ptr;
    next_issue_left = issue_left;
    next_wr_left = wr_left;
    next_pace = pace;
    next_cur_be = cur_be;
    next_hold_valid = hold_valid;
    next_hold_addr = hold_addr;
    next_hold_be = hold_be;
    next_hold_data = hold_data;
    next_done = 1'b0;
    unique case (state)
      rdmt_pkg::RDMT_ENG_IDLE: begin
        if (start && num_elem != '0) begin
          next_state = rdmt_pkg::RDMT_ENG_RUN;
          next_src_ptr = src_start;
          next_dst_ptr = dst_start;
          next_issue_left = num_elem;
          next_wr_left = num_elem;
          next_pace = '0;
          next_cur_be = (num_elem == CNT_W'(1)) ? last_be : full_be;
        end
      end
      rdmt_pkg::RDMT_ENG_RUN, rdmt_pkg::RDMT_ENG_DRAIN: begin
        if (pace != '0) begin
          next_pace = pace - `RDMT_COST_W'(1);
        end
        if (wr_fire) begin
          next_hold_valid = 1'b0;
          next_wr_left = wr_left - CNT_W'(1);
          if (wr_left == CNT_W'(1)) begin
            next_state = rdmt_pkg::RDMT_ENG_IDLE;
            next_done = 1'b1;
          end
        end
        if (rd_fire) begin
          // Bytes keep their order inside the beat: no lane rearrangement
          next_hold_valid = 1'b1;
          next_hold_data = rd_data;
          next_hold_addr = dst_ptr;
          next_hold_be = cur_be;
          next_src_ptr = src_ptr + src_step;
          next_dst_ptr = dst_ptr + dst_step;
          next_pace = cost - `RDMT_COST_W'(1);
          next_issue_left = issue_left - CNT_W'(1);
          next_cur_be = (issue_left == CNT_W'(2)) ? last_be : full_be;
          if (issue_left == CNT_W'(1)) begin
            next_state = rdmt_pkg::RDMT_ENG_DRAIN;
          end
        end
      end
      default: begin
        next_state = rdmt_pkg::RDMT_ENG_IDLE;
      end
    endcase
  end

  // Walker registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= rdmt_pkg::RDMT_ENG_IDLE;
      src_ptr <= '0;
      dst_ptr <= '0;
      issue_left <= '0;
      wr_left <= '0;
      pace <= '0;
      cur_be <= '0;
      hold_valid <= 1'b0;
      hold_addr <= '0;
      hold_be <= '0;
      hold_data <= '0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      src_ptr <= next_src_ptr;
      dst_ptr <= next_dst_ptr;
      issue_left <= next_issue_left;
      wr_left <= next_wr_left;
      pace <= next_pace;
      cur_be <= next_cur_be;
      hold_valid <= next_hold_valid;
      hold_addr <= next_hold_addr;
      hold_be <= next_hold_be;
      hold_data <= next_hold_data;
      done <= next_done;
    end
  end

  // Ports straight from the registers
  assign busy = (state != rdmt_pkg::RDMT_ENG_IDLE);
  assign rd_addr = src_ptr;
  assign rd_be = cur_be;
  assign wr_req = hold_valid;
  assign wr_addr = hold_addr;
  assign wr_be = hold_be;
  assign wr_data = hold_data;

endmodule : rdmt_xfer_engine

// ### hdl/rdmt_dma.sv
// Radar DMA transfer block: takes one descriptor, shapes it into per-engine
// element lists and runs them on two transfer engines.
// Assumes each engine has its own read and write memory ports; a shared bus
// and its arbiter sit outside and throttle the engines through the ready lines.
//
// Notes on behaviour
// - Contiguous mode is a one-dimensional copy of elem_byte_count bytes.
// - A contiguous copy lands the source bytes at the destination in their own order.
// - Contiguous mode moves one 128-bit beat per cycle in steady state.
// - Transpose-write takes element size and element count, reads packed, writes strided.
// - Transpose-write spends four cycles per element of up to 16 bytes.
// - Transpose-read takes element size and element count, reads strided, writes packed.
// - Transpose-read spends one cycle per element of up to 16 bytes.
// - A strided job may be split over the two engines, roughly halving its time.
// - Contention on a shared bus may stretch any job beyond these costs.
// - The strided cost does not depend on element size up to the 128-bit bus width.
`timescale 1ns/1ps
`include "rdmt_map.svh"

module rdmt_dma #(
  parameter int ADDR_W = 32,
  parameter int CNT_W = 16,
  parameter int DATA_W = 128
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Descriptor, sampled on start while idle
  input wire logic start,
  input wire logic [1:0] mode,
  input wire logic split_en,
  input wire logic [ADDR_W-1:0] src_addr,
  input wire logic [ADDR_W-1:0] dst_addr,
  input wire logic [CNT_W-1:0] elem_byte_count,
  input wire logic [CNT_W-1:0] elem_number_count,
  input wire logic [ADDR_W-1:0] src_index,
  input wire logic [ADDR_W-1:0] dst_index,
  // Status
  output logic busy,
  output logic done,
  output logic config_err,
  // Read ports, one per engine
  output logic [1:0] rd_req,
  output logic [1:0][ADDR_W-1:0] rd_addr,
  output logic [1:0][DATA_W/8-1:0] rd_be,
  input wire logic [1:0] rd_ready,
  input wire logic [1:0][DATA_W-1:0] rd_data,
  // Write ports, one per engine
  output logic [1:0] wr_req,
  output logic [1:0][ADDR_W-1:0] wr_addr,
  output logic [1:0][DATA_W/8-1:0] wr_be,
  output logic [1:0][DATA_W-1:0] wr_data,
  input wire logic [1:0] wr_ready
);

  localparam int LANES = DATA_W / 8;
  localparam int BW = $clog2(LANES) + 1;

  // Whether the descriptor can be run at all
  function automatic logic desc_ok(input logic [1:0] m, input logic [CNT_W-1:0] nbytes,
                                   input logic [CNT_W-1:0] nelem);
    logic ok;
    ok = 1'b0;
    if (m == rdmt_pkg::RDMT_MODE_CONTIG) begin
      ok = (nbytes != '0);
    end else if (m == rdmt_pkg::RDMT_MODE_TWRITE || m == rdmt_pkg::RDMT_MODE_TREAD) begin
      // Elements wider than one beat are refused rather than silently cut
      ok = (nbytes != '0) && (nbytes <= CNT_W'(LANES)) && (nelem != '0);
    end
    return ok;
  endfunction : desc_ok

  rdmt_pkg::rdmt_ctl_state_t state, next_state;
  logic [CNT_W-1:0] n_total, n0, n1;
  logic [BW-1:0] e_bytes, l_bytes;
  logic [ADDR_W-1:0] s_step, d_step;
  logic [`RDMT_COST_W-1:0] e_cost;
  logic do_split;
  logic [CNT_W:0] beat_sum;

  // Job setup held for the engines
  logic [1:0][CNT_W-1:0] job_n, next_job_n;
  logic [1:0][ADDR_W-1:0] job_src, next_job_src, job_dst, next_job_dst;
  logic [BW-1:0] job_bytes, next_job_bytes, job_last, next_job_last;
  logic [ADDR_W-1:0] job_sstep, next_job_sstep, job_dstep, next_job_dstep;
  logic [`RDMT_COST_W-1:0] job_cost, next_job_cost;
  logic [1:0] pending, next_pending;
  logic next_done, next_config_err;
  logic [1:0] eng_busy, eng_done;
  logic eng_start;

  assign beat_sum = {1'b0, elem_byte_count} + (CNT_W + 1)'(LANES - 1);

  // Shape the descriptor into element count, sizes, steps and cost
  always_comb begin
    n_total = elem_number_count;
    e_bytes = elem_byte_count[BW-1:0];
    l_bytes = elem_byte_count[BW-1:0];
    s_step = ADDR_W'(elem_byte_count);
    d_step = ADDR_W'(elem_byte_count);
    e_cost = `RDMT_COST_CONT;
    do_split = 1'b0;
    unique case (mode)
      rdmt_pkg::RDMT_MODE_CONTIG: begin
        // Whole beats, then a short tail beat for the remainder
        n_total = CNT_W'(beat_sum >> `RDMT_LANE_SHIFT);
        e_bytes = BW'(LANES);
        l_bytes = (elem_byte_count[`RDMT_LANE_SHIFT-1:0] == '0) ? BW'(LANES)
                  : BW'(elem_byte_count[`RDMT_LANE_SHIFT-1:0]);
        s_step = ADDR_W'(LANES);
        d_step = ADDR_W'(LANES);
        e_cost = `RDMT_COST_CONT;
      end
      rdmt_pkg::RDMT_MODE_TWRITE: begin
        d_step = dst_index;
        e_cost = `RDMT_COST_TWRITE;
        do_split = split_en;
      end
      rdmt_pkg::RDMT_MODE_TREAD: begin
        s_step = src_index;
        e_cost = `RDMT_COST_TREAD;
        do_split = split_en;
      end
      default: begin
        e_cost = `RDMT_COST_CONT;
      end
    endcase
    // Second engine takes the back half; a single element stays on the first
    n1 = do_split ? (n_total >> 1) : '0;
    n0 = n_total - n1;
  end

  // Controller: latch, launch, wait for both engines
  always_comb begin
    next_state = state;
    next_job_n = job_n;
    next_job_src = job_src;
    next_job_dst = job_dst;
    next_job_bytes = job_bytes;
    next_job_last = job_last;
    next_job_sstep = job_sstep;
    next_job_dstep = job_dstep;
    next_job_cost = job_cost;
    next_pending = pending & ~eng_done;
    next_done = 1'b0;
    next_config_err = 1'b0;
    unique case (state)
      rdmt_pkg::RDMT_CTL_IDLE: begin
        if (start) begin
          if (desc_ok(mode, elem_byte_count, elem_number_count)) begin
            next_state = rdmt_pkg::RDMT_CTL_LAUNCH;
            next_job_n[0] = n0;
            next_job_n[1] = n1;
            next_job_src[0] = src_addr;
            next_job_dst[0] = dst_addr;
            next_job_src[1] = src_addr + ADDR_W'(n0) * s_step;
            next_job_dst[1] = dst_addr + ADDR_W'(n0) * d_step;
            next_job_bytes = e_bytes;
            next_job_last = l_bytes;
            next_job_sstep = s_step;
            next_job_dstep = d_step;
            next_job_cost = e_cost;
          end else begin
            next_config_err = 1'b1;
          end
        end
      end
      rdmt_pkg::RDMT_CTL_LAUNCH: begin
        next_state = rdmt_pkg::RDMT_CTL_WAIT;
        next_pending[0] = (job_n[0] != '0);
        next_pending[1] = (job_n[1] != '0);
      end
      rdmt_pkg::RDMT_CTL_WAIT: begin
        // Both halves must have written their last element
        if (next_pending == 2'h0 && eng_busy == 2'h0) begin
          next_state = rdmt_pkg::RDMT_CTL_IDLE;
          next_done = 1'b1;
        end
      end
      default: begin
        next_state = rdmt_pkg::RDMT_CTL_IDLE;
      end
    endcase
  end

  // Controller registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= rdmt_pkg::RDMT_CTL_IDLE;
      job_n <= '0;
      job_src <= '0;
      job_dst <= '0;
      job_bytes <= '0;
      job_last <= '0;
      job_sstep <= '0;
      job_dstep <= '0;
      job_cost <= `RDMT_COST_CONT;
      pending <= 2'h0;
      done <= 1'b0;
      config_err <= 1'b0;
    end else begin
      state <= next_state;
      job_n <= next_job_n;
      job_src <= next_job_src;
      job_dst <= next_job_dst;
      job_bytes <= next_job_bytes;
      job_last <= next_job_last;
      job_sstep <= next_job_sstep;
      job_dstep <= next_job_dstep;
      job_cost <= next_job_cost;
      pending <= next_pending;
      done <= next_done;
      config_err <= next_config_err;
    end
  end

  assign busy = (state != rdmt_pkg::RDMT_CTL_IDLE);
  assign eng_start = (state == rdmt_pkg::RDMT_CTL_LAUNCH);

  // Two engines; their latency is internal, so running both in parallel pays off
  for (genvar g = 0; g < 2; g++) begin : g_eng
    rdmt_xfer_engine #(
      .ADDR_W(ADDR_W),
      .CNT_W(CNT_W),
      .DATA_W(DATA_W)
    ) u_eng (
      .clk_sys(clk_sys),
      .rst(rst),
      .start(eng_start),
      .num_elem(job_n[g]),
      .elem_bytes(job_bytes),
      .last_bytes(job_last),
      .src_start(job_src[g]),
      .dst_start(job_dst[g]),
      .src_step(job_sstep),
      .dst_step(job_dstep),
      .cost(job_cost),
      .busy(eng_busy[g]),
      .done(eng_done[g]),
      .rd_req(rd_req[g]),
      .rd_addr(rd_addr[g]),
      .rd_be(rd_be[g]),
      .rd_ready(rd_ready[g]),
      .rd_data(rd_data[g]),
      .wr_req(wr_req[g]),
      .wr_addr(wr_addr[g]),
      .wr_be(wr_be[g]),
      .wr_data(wr_data[g]),
      .wr_ready(wr_ready[g])
    );
  end

endmodule : rdmt_dma

// ### test/rdmt_dma_monitor.sv
// Checker of the radar DMA block: status and handshake relations at its top ports.
// Assumes one clock domain and the synchronous active-high reset of the design.
`timescale 1ns/1ps
module rdmt_dma_monitor #(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 128
) (
  // Clock, reset and descriptor
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  input wire logic [1:0] mode,
  // Status
  input wire logic busy,
  input wire logic done,
  input wire logic config_err,
  // Memory ports
  input wire logic [1:0] rd_req,
  input wire logic [1:0][ADDR_W-1:0] rd_addr,
  input wire logic [1:0] rd_ready,
  input wire logic [1:0] wr_req,
  input wire logic [1:0][ADDR_W-1:0] wr_addr,
  input wire logic [1:0][DATA_W-1:0] wr_data,
  input wire logic [1:0] wr_ready
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // A strided-write read granted at once, and the end of a streamed read run
  sequence s_tw_read;
    $rose(rd_req[0]) && rd_ready[0] && mode == 2'h1;
  endsequence
  sequence s_stream_end;
    $fell(rd_req[0]) && !rd_req[1] && mode != 2'h1 && wr_ready == 2'h3;
  endsequence
  property p_done_pulse; done |=> !done; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done held too long");
  property p_done_busy; $rose(done) |-> $fell(busy); endproperty
  a_done_busy: assert property (p_done_busy) else $error("busy not ended with done");
  property p_done_quiet; done |-> wr_req == 2'h0 && rd_req == 2'h0; endproperty
  a_done_quiet: assert property (p_done_quiet) else $error("port active at done");
  property p_wr_in_job; wr_req != 2'h0 |-> busy; endproperty
  a_wr_in_job: assert property (p_wr_in_job) else $error("write outside a job");
  property p_tw_gap; s_tw_read |=> !rd_req[0] [*3]; endproperty
  a_tw_gap: assert property (p_tw_gap) else $error("strided write read too soon");
  property p_stream; s_stream_end |-> ##2 done; endproperty
  a_stream: assert property (p_stream) else $error("streamed job slow to end");
  property p_rd_hold;
    rd_req[0] && !rd_ready[0] |=> rd_req[0] && $stable(rd_addr[0]);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read request dropped");
  property p_wr_hold;
    wr_req[1] && !wr_ready[1] |=> wr_req[1] && $stable(wr_addr[1]) && $stable(wr_data[1]);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write request changed");
  property p_cfg; start && !busy && mode == 2'h3 |=> config_err && !busy; endproperty
  a_cfg: assert property (p_cfg) else $error("illegal mode not refused");
endmodule : rdmt_dma_monitor

bind rdmt_dma rdmt_dma_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) rdmt_dma_monitor_i (
  .clk_sys, .rst, .start, .mode, .busy, .done, .config_err, .rd_req, .rd_addr,
  .rd_ready, .wr_req, .wr_addr, .wr_data, .wr_ready);

// ### test/rdmt_mem_model.sv
// Memory behind both engines: one byte store shared by the read and write ports.
// Assumes 4 KiB of space; addresses wrap on 12 bits.
`timescale 1ns/1ps
module rdmt_mem_model (
  // Clock and pacing
  input wire logic clk_sys,
  input wire logic stall_rd,
  input wire logic stall_wr,
  input wire logic [3:0] rnd,
  // Engine ports
  input wire logic [1:0][31:0] rd_addr,
  output logic [1:0] rd_ready,
  output logic [1:0][127:0] rd_data,
  input wire logic [1:0] wr_req,
  input wire logic [1:0][31:0] wr_addr,
  input wire logic [1:0][15:0] wr_be,
  input wire logic [1:0][127:0] wr_data,
  output logic [1:0] wr_ready
);
  logic [7:0] mem [0:4095];
  // Grants follow random bits only while a stall is asked for
  assign rd_ready = stall_rd ? rnd[1:0] : 2'h3;
  assign wr_ready = stall_wr ? rnd[3:2] : 2'h3;
  // Data is valid with the grant only; otherwise the inverse, so a stale use shows
  always_comb begin
    for (int g = 0; g < 2; g++) begin
      for (int i = 0; i < 16; i++) begin
        rd_data[g][8*i +: 8] = mem[12'(rd_addr[g] + i)] ^ {8{!rd_ready[g]}};
      end
    end
  end
  // Accepted writes land byte by byte under their enables
  always @(posedge clk_sys) begin
    for (int g = 0; g < 2; g++) begin
      for (int i = 0; i < 16; i++) begin
        if (wr_req[g] && wr_ready[g] && wr_be[g][i]) begin
          mem[12'(wr_addr[g] + i)] <= wr_data[g][8*i +: 8];
        end
      end
    end
  end
endmodule : rdmt_mem_model

// ### test/rdmt_dma_tb_top.sv
// Testbench of the radar DMA block: runs every mode, split and refused descriptor.
// Assumes the memory model beside it; a byte copy of memory predicts each result.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, a, b); end end
module rdmt_dma_tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic split_en = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [31:0] src_addr = 32'h0, dst_addr = 32'h0, src_index = 32'h0, dst_index = 32'h0;
  logic [15:0] elem_byte_count = 16'h0, elem_number_count = 16'h0;
  logic busy, done, config_err, stall_rd = 1'b0, stall_wr = 1'b0;
  logic [1:0] rd_req, rd_ready, wr_req, wr_ready;
  logic [1:0][31:0] rd_addr, wr_addr;
  logic [1:0][15:0] rd_be, wr_be;
  logic [1:0][127:0] rd_data, wr_data;
  logic [3:0] rnd = 4'h0;
  logic [31:0] seed = 32'he1a6, gseed = 32'he1a6;
  logic [7:0] ref_mem [0:4095];
  int fail_count = 0, num_checks = 0, cycles = 0;

  always #25 clk_sys = ~clk_sys;

  rdmt_dma rdmt_dma_i (.clk_sys, .rst, .start, .mode, .split_en, .src_addr, .dst_addr,
    .elem_byte_count, .elem_number_count, .src_index, .dst_index, .busy, .done,
    .config_err, .rd_req, .rd_addr, .rd_be, .rd_ready, .rd_data, .wr_req, .wr_addr,
    .wr_be, .wr_data, .wr_ready);
  rdmt_mem_model rdmt_mem_model_i (.clk_sys, .stall_rd, .stall_wr, .rnd, .rd_addr,
    .rd_ready, .rd_data, .wr_req, .wr_addr, .wr_be, .wr_data, .wr_ready);

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // Fresh grant bits each edge; the ceiling cuts a hang well past the longest run
  always @(posedge clk_sys) begin
    gseed <= xs(gseed);
    rnd <= gseed[3:0];
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end

  // Every strided grant carries the low-lane mask of the element size, read and write alike
  always @(posedge clk_sys) begin
    for (int g = 0; g < 2; g++) begin
      if (busy && mode != 2'h0 && rd_req[g] && rd_ready[g]) begin
        `CHK(rd_be[g], 16'((32'h1 << elem_byte_count) - 1))
      end
      if (busy && mode != 2'h0 && wr_req[g] && wr_ready[g]) begin
        `CHK(wr_be[g], 16'((32'h1 << elem_byte_count) - 1))
      end
    end
  end

  // One descriptor: drive, wait for its answer, predict and compare all memory
  task automatic run_job(input int t, input logic [1:0] md, input logic sp, input int esz,
                         input int n, input logic srd, input logic swr);
    int cyc, n0, src, dst, ss, ds, exp_cyc;
    logic bad;
    cyc = 0;
    bad = md == 2'h3 || esz == 0 || (md != 2'h0 && (esz > 16 || n == 0));
    seed = xs(seed);
    src = 256 + seed[3:0];
    dst = 2048 + seed[7:4];
    ss = (md == 2'h2) ? 36 : esz;
    ds = (md == 2'h1) ? 36 : esz;
    @(posedge clk_sys);
    mode <= md;
    split_en <= sp;
    src_addr <= src;
    dst_addr <= dst;
    src_index <= 32'h24;
    dst_index <= 32'h24;
    elem_byte_count <= 16'(esz);
    elem_number_count <= 16'(n);
    stall_rd <= srd;
    stall_wr <= swr;
    start <= 1'b1;
    do begin
      @(posedge clk_sys);
      start <= 1'b0;
      #1;
      cyc++;
    end while (done !== 1'b1 && config_err !== 1'b1 && cyc < 400);
    n0 = (sp && md != 2'h0 && n > 1) ? n - n / 2 : n;
    if (md == 2'h0) begin
      n0 = (esz + 15) / 16;
      n = 1;
    end
    exp_cyc = (md == 2'h1) ? 4 * n0 + 1 : n0 + 4;
    `CHK(busy, 1'b0)
    if (bad) begin
      `CHK(config_err, 1'b1)
      `CHK(cyc, 1)
    end else begin
      `CHK(done, 1'b1)
      if (!(srd || swr)) `CHK(cyc, exp_cyc)
      for (int e = 0; e < n; e++) begin
        for (int b = 0; b < esz; b++) begin
          ref_mem[dst + e * ds + b] = ref_mem[src + e * ss + b];
        end
      end
    end
    for (int a = 0; a < 4096; a++) begin
      `CHK(rdmt_mem_model_i.mem[a], ref_mem[a])
    end
    $display("test %0d mode %0d ended after %0d cycles", t, md, cyc);
  endtask : run_job

  // Random memory image, reset, then the descriptor table
  initial begin
    for (int a = 0; a < 4096; a++) begin
      seed = xs(seed);
      rdmt_mem_model_i.mem[a] = seed[7:0];
      ref_mem[a] = seed[7:0];
    end
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    run_job(1, 2'h0, 1'b0, 40, 1, 1'b0, 1'b0);
    run_job(2, 2'h0, 1'b1, 16, 1, 1'b0, 1'b0);
    run_job(3, 2'h0, 1'b0, 100, 1, 1'b0, 1'b0);
    run_job(4, 2'h1, 1'b0, 4, 6, 1'b0, 1'b0);
    run_job(5, 2'h1, 1'b0, 16, 5, 1'b0, 1'b0);
    run_job(6, 2'h1, 1'b1, 4, 7, 1'b0, 1'b0);
    run_job(7, 2'h2, 1'b0, 4, 8, 1'b0, 1'b0);
    run_job(8, 2'h2, 1'b1, 16, 5, 1'b0, 1'b0);
    run_job(9, 2'h2, 1'b1, 1, 1, 1'b0, 1'b0);
    run_job(10, 2'h1, 1'b1, 8, 6, 1'b1, 1'b1);
    run_job(11, 2'h2, 1'b1, 3, 9, 1'b1, 1'b0);
    run_job(12, 2'h3, 1'b0, 4, 2, 1'b0, 1'b0);
    run_job(13, 2'h0, 1'b0, 0, 1, 1'b0, 1'b0);
    run_job(14, 2'h2, 1'b0, 17, 2, 1'b0, 1'b0);
    run_job(15, 2'h1, 1'b0, 4, 0, 1'b0, 1'b0);
    conclude();
  end
endmodule : rdmt_dma_tb_top
